/* core/efsc_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants, field layouts and carriers for the external function block
// Assumes: One system clock, classic Wishbone register access
// Notes:   Function code bit 0 is the MSB, bit 31 the LSB of the 32-bit word
//
// Summary of operation
// - Loop, data, instruction bus hangs halt controller
// - Controller bus parity errors halt controller
// - Pager fetch or store hang stops pager
// - Errors 02 and 0B only latch, interrupt
// - Any set error requests sequential interrupt
// - Error code senses bit 30 or 31
// - Present state picks bit 28/29 new state
// - 38004011 senses loop error, clears it if set
// - Eight sequential interrupts, sense then replace
// - Sequential interrupt new state from bit 28/29
// - Sequential interrupts addressed C0 to DC by four
// - Vectors 300-334, levels 4-7, D8 panel, DC errors
// - Codes 38002n0 reset unit n, 02 to 2E
// - Distinct clears per unit, 38002300 master clear
// - Narrow host words zero-extended, upper bits dropped
// - Wide host words truncated, excess written zero
// - Buffered I/O port always wins memory arbitration
// - Buffered I/O word: 32 data plus parity
// - Sense bit returned to issuing host
// - Clear state uses 30/28, set uses 31/29
// - Error 00 illegal instruction halts controller
//////////////////////////////////////////////////////////////////////////////
package efsc_pkg;

	// Register byte offsets
	localparam logic [7:0]  ADDR_FUNC      = 8'h00;
	localparam logic [7:0]  ADDR_SENSE     = 8'h04;
	localparam logic [7:0]  ADDR_ERR       = 8'h08;
	localparam logic [7:0]  ADDR_SEQ       = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS    = 8'h10;
	localparam logic [7:0]  ADDR_HOSTW     = 8'h14;

	// Function code fields
	localparam logic [19:0] PFX_ERROR      = 20'h38004;
	localparam logic [19:0] PFX_SEQ        = 20'h38012;
	localparam logic [19:0] PFX_RESET      = 20'h38002;
	localparam int          BIT_SENSE_SET  = 0;
	localparam int          BIT_SENSE_CLR  = 1;
	localparam int          BIT_NEW_SET    = 2;
	localparam int          BIT_NEW_CLR    = 3;

	// Selector ranges
	localparam logic [7:0]  SEQ_FIRST      = 8'hC0;
	localparam logic [7:0]  SEQ_LAST       = 8'hDC;
	localparam logic [7:0]  RST_FIRST      = 8'h02;
	localparam logic [7:0]  RST_LAST       = 8'h2E;
	localparam logic [7:0]  N_CLR_ERR      = 8'h03;
	localparam logic [7:0]  N_MASTER       = 8'h30;

	// Error indicator classes
	localparam int          NUM_ERR        = 16;
	localparam logic [15:0] ERR_VALID      = 16'h0B7F;
	localparam logic [15:0] ERR_HALT_CTRL  = 16'h031B;
	localparam logic [15:0] ERR_STOP_PAGER = 16'h0060;

	// Sequential interrupts
	localparam int          NUM_SEQ        = 8;
	localparam int          SEQ_ERR_IDX    = 7;
	localparam logic [2:0]  SEQ_BASE_LEVEL = 3'h4;

	// Other sizes and resets
	localparam int          NUM_UNITS      = 49;
	localparam int          NUM_SRC        = 3;
	localparam int          NUM_MEM_REQ    = 4;
	localparam int          HOST_MAX       = 64;
	localparam logic [6:0]  HOSTW_RST      = 7'h20;
	localparam logic [6:0]  HOSTW_MAX      = 7'h40;
	localparam logic        BIO_ODD        = 1'b1;
	localparam int          ST_CTRL_HALT   = 0;
	localparam int          ST_PAGER_INOP  = 1;
	localparam int          ST_SEQ_IRQ     = 2;

	typedef struct packed {
		logic        valid;
		logic [31:0] code;
	} efsc_exf_req_type;

	typedef struct packed {
		logic valid;
		logic bit_val;
	} efsc_sense_type;

	typedef struct packed {
		logic [31:0] data;
		logic        parity;
	} efsc_bio_word_type;

endpackage

/* core/efsc_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: External function decoder with error and sequential interrupt state
// Assumes: All inputs synchronous to clk_i, Wishbone classic slave access
// Notes:   Wishbone FUNC write has priority over port issuers in its ack cycle
//////////////////////////////////////////////////////////////////////////////
module efsc_top (
	input  wire logic                                        clk_i,
	input  wire logic                                        rst_i,
	input  wire logic                                        wb_cyc_i,
	input  wire logic                                        wb_stb_i,
	input  wire logic                                        wb_we_i,
	input  wire logic [7:0]                                  wb_adr_i,
	input  wire logic [3:0]                                  wb_sel_i,
	input  wire logic [31:0]                                 wb_dat_i,
	output logic      [31:0]                                 wb_dat_o,
	output logic                                             wb_ack_o,
	input  wire efsc_pkg::efsc_exf_req_type [efsc_pkg::NUM_SRC-1:0] exf_req_i,
	output logic      [efsc_pkg::NUM_SRC-1:0]                exf_ready_o,
	output efsc_pkg::efsc_sense_type [efsc_pkg::NUM_SRC-1:0] sense_o,
	input  wire logic [efsc_pkg::NUM_ERR-1:0]                err_event_i,
	input  wire logic [efsc_pkg::NUM_SEQ-1:0]                seq_event_i,
	output logic                                             ctrl_halt_o,
	output logic                                             pager_inop_o,
	output logic                                             seq_irq_o,
	output logic                                             seq_pending_o,
	output logic      [7:0]                                  seq_vector_o,
	output logic      [2:0]                                  seq_level_o,
	output logic      [efsc_pkg::NUM_UNITS-1:0]              unit_reset_o,
	input  wire logic [efsc_pkg::HOST_MAX-1:0]               host_rdata_i,
	output logic      [31:0]                                 dma_rdata_o,
	input  wire logic [31:0]                                 dma_wdata_i,
	output logic      [efsc_pkg::HOST_MAX-1:0]               host_wdata_o,
	input  wire logic [efsc_pkg::NUM_MEM_REQ-1:0]            mem_req_i,
	output logic      [efsc_pkg::NUM_MEM_REQ-1:0]            mem_gnt_o,
	input  wire efsc_pkg::efsc_bio_word_type                 bio_rx_i,
	input  wire logic                                        bio_rx_valid_i,
	output efsc_pkg::efsc_bio_word_type                      bio_rx_o,
	output logic                                             bio_rx_valid_o,
	output logic                                             bio_par_err_o,
	input  wire logic [31:0]                                 bio_tx_data_i,
	input  wire logic                                        bio_tx_valid_i,
	output efsc_pkg::efsc_bio_word_type                      bio_tx_o,
	output logic                                             bio_tx_valid_o
);
	import efsc_pkg::*;

	// Width mask for host words of 1 to 64 bits
	function automatic logic [HOST_MAX-1:0] width_mask(input logic [6:0] w);
		logic [HOST_MAX-1:0] m;
		m = '0;
		for (int b = 0; b < HOST_MAX; b++) begin
			m[b] = (7'(b) < w);
		end
		return m;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// State registers and next values
	logic                   ack_q, ack_d;
	logic [31:0]            dat_q, dat_d;
	logic [31:0]            func_q, func_d;
	logic                   wsense_q, wsense_d;
	logic [NUM_ERR-1:0]     err_q, err_d;
	logic [NUM_SEQ-1:0]     seq_q, seq_d;
	logic [NUM_UNITS-1:0]   urst_q, urst_d;
	logic [6:0]             hostw_q, hostw_d;
	efsc_sense_type [NUM_SRC-1:0] sense_q, sense_d;
	logic [31:0]            dmar_q, dmar_d;
	logic [HOST_MAX-1:0]    hostwr_q, hostwr_d;
	efsc_bio_word_type      brx_q, brx_d, btx_q, btx_d;
	logic                   brxv_q, brxv_d, btxv_q, btxv_d, bpe_q, bpe_d;

	// Decode and execute signals
	logic                   wb_req;
	logic                   wb_exec;
	logic [NUM_SRC-1:0]     src_valid;
	logic [NUM_SRC-1:0]     src_gnt;
	logic                   exec_valid;
	logic [31:0]            exec_code;
	logic [19:0]            pfx;
	logic [7:0]             sel_n;
	logic [7:0]             seq_off;
	logic [3:0]             eidx;
	logic [2:0]             sidx;
	logic                   is_err, is_seq, is_rst, clr_err;
	logic                   cur, sense_bit, new_bit;
	logic                   any_err;
	logic [NUM_SEQ-1:0]     seq_eff;

	//////////////////////////////////////////////////////////////////////////
	// Bus request qualification
	assign wb_req  = wb_cyc_i & wb_stb_i;
	assign wb_exec = wb_req & wb_we_i & ack_q & (wb_adr_i == ADDR_FUNC) & (wb_sel_i == 4'hF);

	// Source priority, index 0 highest, bus write blocks all
	generate
		for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
			assign src_valid[i]   = exf_req_i[i].valid;
			if (i == 0) begin : g_first
				assign exf_ready_o[i] = ~wb_exec;
			end else begin : g_rest
				assign exf_ready_o[i] = ~wb_exec & ~(|src_valid[i-1:0]);
			end
			assign src_gnt[i] = src_valid[i] & exf_ready_o[i];
		end
	endgenerate

	// Memory arbitration, buffered I/O on bit 0 always first
	assign mem_gnt_o = mem_req_i & (~mem_req_i + 4'h1);

	// Selected function code, one per cycle
	always_comb begin
		exec_valid = wb_exec;
		exec_code  = wb_dat_i;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (src_gnt[i]) begin
				exec_valid = 1'b1;
				exec_code  = exf_req_i[i].code;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Function code field decode
	assign pfx     = exec_code[31:12];
	assign sel_n   = exec_code[11:4];
	assign seq_off = sel_n - SEQ_FIRST;
	assign eidx    = sel_n[3:0];
	assign sidx    = seq_off[4:2];
	assign any_err = |(err_q & ERR_VALID);

	// Error number 0B etc. fold into the shared request
	assign seq_eff = seq_q | (NUM_SEQ'(any_err) << SEQ_ERR_IDX);

	// Class decode of the executed code
	always_comb begin
		is_err  = exec_valid & (pfx == PFX_ERROR) & (sel_n[7:4] == 4'h0);
		is_seq  = exec_valid & (pfx == PFX_SEQ) & (sel_n >= SEQ_FIRST) & (sel_n <= SEQ_LAST)
			& (sel_n[1:0] == 2'h0);
		is_rst  = exec_valid & (pfx == PFX_RESET) & (exec_code[3:0] == 4'h0)
			& (((sel_n >= RST_FIRST) & (sel_n <= RST_LAST)) | (sel_n == N_MASTER));
		clr_err = is_rst & ((sel_n == N_CLR_ERR) | (sel_n == N_MASTER));
		cur     = 1'b0;
		if (is_err) begin
			cur = err_q[eidx] & ERR_VALID[eidx];
		end else if (is_seq) begin
			cur = seq_eff[sidx];
		end
	end

	// Sense then replace selection
	always_comb begin
		sense_bit = 1'b0;
		new_bit   = 1'b0;
		if (is_err | is_seq) begin
			sense_bit = cur ? exec_code[BIT_SENSE_SET] : exec_code[BIT_SENSE_CLR];
			new_bit   = cur ? exec_code[BIT_NEW_SET] : exec_code[BIT_NEW_CLR];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Error indicators, detector set wins over any clear
	always_comb begin
		err_d = err_q;
		if (is_err) begin
			err_d[eidx] = new_bit;
		end
		if (clr_err) begin
			err_d = '0;
		end
		err_d = (err_d | err_event_i) & ERR_VALID;
	end

	// Sequential interrupts, event set wins over clear
	always_comb begin
		seq_d = seq_q;
		if (is_seq) begin
			seq_d[sidx] = new_bit;
		end
		if (clr_err) begin
			seq_d = '0;
		end
		seq_d = seq_d | seq_event_i;
	end

	// Unit reset pulses, master clear hits all units
	always_comb begin
		urst_d = '0;
		if (is_rst) begin
			if (sel_n == N_MASTER) begin
				urst_d = '1;
			end else begin
				urst_d[sel_n[5:0]] = 1'b1;
			end
		end
	end

	// Sense return to issuing source
	always_comb begin
		sense_d  = '0;
		wsense_d = wsense_q;
		func_d   = func_q;
		for (int i = 0; i < NUM_SRC; i++) begin
			sense_d[i].valid   = src_gnt[i];
			sense_d[i].bit_val = src_gnt[i] & sense_bit;
		end
		if (exec_valid) begin
			func_d = exec_code;
		end
		if (wb_exec) begin
			wsense_d = sense_bit;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after request, drops after
	always_comb begin
		ack_d   = wb_req & ~ack_q;
		dat_d   = dat_q;
		hostw_d = hostw_q;
		if (wb_req & ~ack_q & ~wb_we_i) begin
			dat_d = '0;
			case (wb_adr_i)
				ADDR_FUNC:   dat_d = func_q;
				ADDR_SENSE:  dat_d = {31'h0, wsense_q};
				ADDR_ERR:    dat_d = {16'h0, err_q};
				ADDR_SEQ:    dat_d = {24'h0, seq_eff};
				ADDR_STATUS: dat_d = {29'h0, seq_irq_o, pager_inop_o, ctrl_halt_o};
				ADDR_HOSTW:  dat_d = {25'h0, hostw_q};
				default:     dat_d = '0;
			endcase
		end
		if (wb_req & wb_we_i & ack_q & (wb_adr_i == ADDR_HOSTW) & wb_sel_i[0]) begin
			if ((wb_dat_i[6:0] != 7'h0) & (wb_dat_i[6:0] <= HOSTW_MAX) & (wb_dat_i[31:7] == 25'h0)) begin
				hostw_d = wb_dat_i[6:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Host word width adaptation on the memory access path
	always_comb begin
		logic [HOST_MAX-1:0] m;
		m        = width_mask(hostw_q);
		dmar_d   = 32'(host_rdata_i & m);
		hostwr_d = {32'h0, dma_wdata_i} & m;
	end

	// Buffered I/O word check and parity generation
	always_comb begin
		brx_d  = bio_rx_i;
		brxv_d = bio_rx_valid_i;
		bpe_d  = bio_rx_valid_i & ((^{bio_rx_i.data, bio_rx_i.parity}) != BIO_ODD);
		btx_d.data   = bio_tx_data_i;
		btx_d.parity = (^bio_tx_data_i) ^ BIO_ODD;
		btxv_d = bio_tx_valid_i;
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_q    <= 1'b0;
			dat_q    <= '0;
			func_q   <= '0;
			wsense_q <= 1'b0;
			err_q    <= '0;
			seq_q    <= '0;
			urst_q   <= '0;
			hostw_q  <= HOSTW_RST;
			sense_q  <= '0;
			dmar_q   <= '0;
			hostwr_q <= '0;
			brx_q    <= '0;
			brxv_q   <= 1'b0;
			bpe_q    <= 1'b0;
			btx_q    <= '0;
			btxv_q   <= 1'b0;
		end else begin
			ack_q    <= ack_d;
			dat_q    <= dat_d;
			func_q   <= func_d;
			wsense_q <= wsense_d;
			err_q    <= err_d;
			seq_q    <= seq_d;
			urst_q   <= urst_d;
			hostw_q  <= hostw_d;
			sense_q  <= sense_d;
			dmar_q   <= dmar_d;
			hostwr_q <= hostwr_d;
			brx_q    <= brx_d;
			brxv_q   <= brxv_d;
			bpe_q    <= bpe_d;
			btx_q    <= btx_d;
			btxv_q   <= btxv_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Highest pending sequential interrupt, two per level
	always_comb begin
		seq_pending_o = |seq_eff;
		seq_vector_o  = SEQ_FIRST;
		seq_level_o   = SEQ_BASE_LEVEL;
		for (int i = 0; i < NUM_SEQ; i++) begin
			if (seq_eff[i]) begin
				seq_vector_o = SEQ_FIRST + {3'h0, 3'(i), 2'h0};
				seq_level_o  = SEQ_BASE_LEVEL + 3'(i >> 1);
			end
		end
	end

	// Status outputs from stored indicators
	assign ctrl_halt_o    = |(err_q & ERR_HALT_CTRL);
	assign pager_inop_o   = |(err_q & ERR_STOP_PAGER);
	assign seq_irq_o      = any_err;
	assign wb_ack_o       = ack_q;
	assign wb_dat_o       = dat_q;
	assign sense_o        = sense_q;
	assign unit_reset_o   = urst_q;
	assign dma_rdata_o    = dmar_q;
	assign host_wdata_o   = hostwr_q;
	assign bio_rx_o       = brx_q;
	assign bio_rx_valid_o = brxv_q;
	assign bio_par_err_o  = bpe_q;
	assign bio_tx_o       = btx_q;
	assign bio_tx_valid_o = btxv_q;

endmodule

/* tb/efsc_top_properties.sv */
//////////////////////////////////////
// Purpose: Port checks on efsc_top
// Assumes: Host codes arrive on port 2
// Notes:   Bound below to every efsc_top
//////////////////////////////////////
module efsc_top_properties (
	input wire logic                             clk_i,
	input wire logic                             rst_i,
	input wire efsc_pkg::efsc_exf_req_type [2:0] exf_req_i,
	input wire logic [2:0]                       exf_ready_o,
	input wire efsc_pkg::efsc_sense_type [2:0]   sense_o,
	input wire logic [15:0]                      err_event_i,
	input wire logic                             ctrl_halt_o,
	input wire logic                             pager_inop_o,
	input wire logic                             seq_irq_o,
	input wire logic [48:0]                      unit_reset_o,
	input wire logic [3:0]                       mem_req_i,
	input wire logic [3:0]                       mem_gnt_o,
	input wire efsc_pkg::efsc_bio_word_type      bio_rx_i,
	input wire logic                             bio_rx_valid_i,
	input wire logic                             bio_par_err_o,
	input wire logic [31:0]                      bio_tx_data_i,
	input wire logic                             bio_tx_valid_i,
	input wire efsc_pkg::efsc_bio_word_type      bio_tx_o,
	input wire logic                             bio_tx_valid_o
);
	import efsc_pkg::*;

	// Host port code taken at this edge
	logic take_h;
	assign take_h = exf_req_i[2].valid && exf_ready_o[2];

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	//////////////////////////////////////
	// Indicator effects, one cycle on
	a_ctrl_hang_halt: assert property (|{err_event_i[4:3], err_event_i[1:0]} |=> ctrl_halt_o)
		else $error("no halt");
	a_ctrl_par_halt: assert property (|err_event_i[9:8] |=> ctrl_halt_o)
		else $error("no parity halt");
	a_pager_stop: assert property (|err_event_i[6:5] |=> pager_inop_o)
		else $error("pager runs");
	a_error_irq: assert property (|(err_event_i & ERR_VALID) |=> seq_irq_o)
		else $error("no irq");

	//////////////////////////////////////
	// Function code answers
	a_sense_pulse: assert property (take_h |=> sense_o[2].valid)
		else $error("sense pulse wrong");
	a_sense_quiet: assert property (!take_h |=> !sense_o[2].valid)
		else $error("sense without code");
	a_master_clear: assert property (take_h && exf_req_i[2].code == {PFX_RESET, N_MASTER, 4'h0}
		|=> &unit_reset_o) else $error("master clear missed");
	a_unit_reset: assert property (take_h && exf_req_i[2].code[31:12] == PFX_RESET
		&& exf_req_i[2].code[3:0] == 4'h0 && exf_req_i[2].code[11:4] inside {[RST_FIRST:RST_LAST]}
		|=> unit_reset_o[$past(exf_req_i[2].code[9:4])]) else $error("unit not reset");

	//////////////////////////////////////
	// Arbiter and buffered I/O words
	a_bio_first: assert property (mem_req_i[0] |-> mem_gnt_o == 4'h1)
		else $error("port not first");
	a_tx_word: assert property (bio_tx_valid_i |=> bio_tx_valid_o && bio_tx_o.data == $past(bio_tx_data_i)
		&& (^{bio_tx_o.data, bio_tx_o.parity}) == BIO_ODD) else $error("tx word wrong");
	a_rx_parity: assert property (bio_rx_valid_i && (^{bio_rx_i.data, bio_rx_i.parity}) != BIO_ODD
		|=> bio_par_err_o) else $error("parity missed");
endmodule

bind efsc_top efsc_top_properties props (
	.clk_i, .rst_i, .exf_req_i, .exf_ready_o, .sense_o, .err_event_i, .ctrl_halt_o, .pager_inop_o,
	.seq_irq_o, .unit_reset_o, .mem_req_i, .mem_gnt_o, .bio_rx_i, .bio_rx_valid_i, .bio_par_err_o,
	.bio_tx_data_i, .bio_tx_valid_i, .bio_tx_o, .bio_tx_valid_o
);

/* tb/efsc_cabinet.sv */
//////////////////////////////////////
// Purpose: Host side cabinet issuing codes
// Assumes: Caller starts just after an edge
// Notes:   Released code lines show inverse
//////////////////////////////////////
module efsc_cabinet (
	input  wire logic                    clk_i,
	input  wire logic                    ready_i,
	input  wire efsc_pkg::efsc_sense_type sense_i,
	output efsc_pkg::efsc_exf_req_type   req_o
);
	import efsc_pkg::*;

	// Spare code prefix, arbitrary, never decoded by the main frame
	localparam logic [19:0] SPARE_PFX = 20'h38FFF;
	int host_irqs = 0;

	// Idle, nothing pending
	initial req_o = '0;

	// One code at a time, sense handed back
	task automatic issue(input logic [31:0] c, output logic s);
		int n;
		n = 0;
		req_o <= '{1'b1, c};
		do begin
			@(posedge clk_i);
			n++;
		end while (ready_i !== 1'b1 && n < 99);
		if (c[31:12] == SPARE_PFX) host_irqs++;
		req_o <= '{1'b0, ~c};
		@(posedge clk_i);
		s = sense_i.valid === 1'b1 ? sense_i.bit_val : 1'bx;
	endtask
endmodule

/* tb/efsc_top_test.sv */
//////////////////////////////////////
// Purpose: Self-checking bench for efsc_top
// Assumes: 250 MHz clock, codes from host
// Notes:   Issuer ports 0 and 1 stay idle
//////////////////////////////////////
module efsc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import efsc_pkg::*;

	typedef struct packed {
		logic [31:0] c;
		logic        s;
		logic [2:0]  st;
	} efsc_row_type;

	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	logic                   wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0]             wb_adr_i = '0, seq_event_i = '0, seq_vector_o;
	logic [31:0]            wb_dat_i = '0, wb_dat_o, q, dma_rdata_o, dma_wdata_i = 32'hFFFFFFFF;
	efsc_exf_req_type [1:0] req_lo = '0;
	efsc_exf_req_type       cab_req;
	logic [2:0]             ready, seq_level_o;
	efsc_sense_type [2:0]   sense;
	logic [15:0]            err_event_i = '0;
	logic                   ctrl_halt_o, pager_inop_o, seq_irq_o, s;
	logic                   seq_pending_o, bio_rx_valid_o, bio_tx_valid_o;
	logic [63:0]            host_rdata_i = 64'h0123456789ABCDEF, host_wdata_o, m;
	logic [3:0]             mem_req_i = '0, mem_gnt_o;
	efsc_bio_word_type      bio_rx_i = '0, bio_tx_o, bio_rx_o;
	logic                   bio_rx_valid_i = 1'b0, bio_par_err_o, bio_tx_valid_i = 1'b0;
	logic [31:0]            bio_tx_data_i = '0;
	int                     mismatches = 0, n_compared = 0;
	logic [6:0]             hw [3] = '{7'h01, 7'h10, 7'h40};
	efsc_row_type           rows [15] = '{
		'{32'h38004015, 1'b0, 3'h0}, '{32'h3800401C, 1'b0, 3'h5}, '{32'h38004015, 1'b1, 3'h5},
		'{32'h38004011, 1'b1, 3'h0}, '{32'h38004011, 1'b0, 3'h0}, '{32'h3800402C, 1'b0, 3'h4},
		'{32'h38004026, 1'b0, 3'h4}, '{32'h38004020, 1'b0, 3'h0}, '{32'h3800406C, 1'b0, 3'h6},
		'{32'h38002030, 1'b0, 3'h0}, '{32'h380040BC, 1'b0, 3'h4}, '{32'h3800409C, 1'b0, 3'h5},
		'{32'h3800407C, 1'b0, 3'h5}, '{32'h38004076, 1'b1, 3'h5}, '{32'h38002300, 1'b0, 3'h0}};

	// Design and host cabinet
	efsc_top uut (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .exf_req_i({cab_req, req_lo}), .exf_ready_o(ready), .sense_o(sense),
		.err_event_i, .seq_event_i, .ctrl_halt_o, .pager_inop_o, .seq_irq_o, .seq_pending_o,
		.seq_vector_o, .seq_level_o, .unit_reset_o(), .host_rdata_i, .dma_rdata_o, .dma_wdata_i,
		.host_wdata_o, .mem_req_i, .mem_gnt_o, .bio_rx_i, .bio_rx_valid_i, .bio_rx_o,
		.bio_rx_valid_o, .bio_par_err_o, .bio_tx_data_i, .bio_tx_valid_i, .bio_tx_o, .bio_tx_valid_o
	);
	efsc_cabinet cab (.clk_i, .ready_i(ready[2]), .sense_i(sense[2]), .req_o(cab_req));

	// 4 ns clock
	always #2 clk_i = ~clk_i;

	//////////////////////////////////////
	// Compare, bus cycle, verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 99);
		if (wb_ack_o !== 1'b1) begin
			mismatches++;
			$display("BAD %0t bus timeout", $time);
		end
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wrap_up;
		if (mismatches == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	//////////////////////////////////////
	// Main sequence, resets only from host
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (rows[i]) begin
			cab.issue(rows[i].c, s);
			chk(s, rows[i].s);
			wb(ADDR_STATUS, 1'b0, '0, q);
			chk(q, rows[i].st);
		end
		// Each sequential interrupt in turn
		for (int k = 0; k < 8; k++) begin
			cab.issue({20'h38012, 8'(8'hC0 + 4 * k), 4'hC}, s);
			chk({seq_pending_o, seq_vector_o}, {1'b1, 8'(8'hC0 + 4 * k)});
			chk(seq_level_o, 4 + k / 2);
		end
		cab.issue(32'h38012DC1, s);
		chk(s, 1'b1);
		wb(ADDR_SEQ, 1'b0, '0, q);
		chk(q, 32'h7F);
		// Detector events, bit 7 unassigned
		err_event_i <= 16'h01B1;
		seq_event_i <= 8'h04;
		@(posedge clk_i);
		err_event_i <= '0;
		seq_event_i <= '0;
		@(posedge clk_i);
		wb(ADDR_ERR, 1'b0, '0, q);
		chk(q, 32'h0131);
		chk({seq_vector_o, ctrl_halt_o, pager_inop_o, seq_irq_o}, {8'hDC, 3'h7});
		cab.issue(32'h38002030, s);
		wb(ADDR_SEQ, 1'b0, '0, q);
		chk({seq_pending_o, q}, 33'h0);
		wb(8'h20, 1'b0, '0, q);
		chk(q, 32'h0);
		// Host word widths on the memory path
		foreach (hw[i]) begin
			wb(ADDR_HOSTW, 1'b1, 32'(hw[i]), q);
			m = hw[i] == 7'h40 ? '1 : (64'h1 << hw[i]) - 64'h1;
			repeat (2) @(posedge clk_i);
			chk(dma_rdata_o, 32'(host_rdata_i & m));
			chk(host_wdata_o, m & 64'hFFFFFFFF);
		end
		// Arbiter and buffered I/O words
		mem_req_i <= 4'hE;
		bio_tx_data_i <= 32'h3;
		bio_tx_valid_i <= 1'b1;
		bio_rx_i <= '{32'h1, 1'b1};
		bio_rx_valid_i <= 1'b1;
		@(posedge clk_i);
		chk(mem_gnt_o, 4'h2);
		mem_req_i <= 4'hF;
		bio_tx_valid_i <= 1'b0;
		bio_rx_valid_i <= 1'b0;
		@(posedge clk_i);
		chk(mem_gnt_o, 4'h1);
		chk({bio_tx_o, bio_par_err_o}, {32'h3, 1'b1, 1'b1});
		chk({bio_tx_valid_o, bio_rx_valid_o, bio_rx_o}, {2'h3, 32'h1, 1'b1});
		// Code issued over the bus, then a spare code from the host
		wb(ADDR_FUNC, 1'b1, 32'h3800402E, q);
		wb(ADDR_SENSE, 1'b0, '0, q);
		chk(q, 32'h1);
		wb(ADDR_STATUS, 1'b0, '0, q);
		chk(q, 32'h4);
		cab.issue(32'h38FFF005, s);
		chk({s, cab.host_irqs}, {1'b0, 32'd1});
		wb(ADDR_FUNC, 1'b0, '0, q);
		chk(q, 32'h38FFF005);
		// Second reset with an error latched
		cab.issue(32'h3800401C, s);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(ADDR_HOSTW, 1'b0, '0, q);
		chk({q, ctrl_halt_o, seq_vector_o, seq_level_o}, {32'h20, 1'b0, 8'hC0, 3'h4});
		wrap_up();
	end

	// Watchdog against a hang
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule
